// ===== acc_cfg.svh
// Register map, field positions and reset values of the comparator control.
// Assumes an 8-bit register port with a 3-bit word address.
// Operation
// R1: Pin select bit 7 hands the two input pins to the comparator.
// R2: Pull-ups on shared input pins drop while comparator selected or enabled.
// R3: On/off bit 6 powers the comparator; off draws no power.
// R4: Polarity bit 5 passes the result straight or inverted.
// R5: Result bit 4 reads 1 when positive exceeds negative, polarity clear.
// R6: Result drives output pin only when path bit 3 is 0 and pins selected.
// R7: Edge field bits 2..1: 00 rising, 01 falling, 1x both edges.
// R8: Hysteresis bit 0 turns limited hysteresis on.
// R9: Result change sets request flag; with enable it requests the vector.
// R10: Edges come from the internal result bit, never the output pin.
// R11: Flag set by result change during sleep or idle wakes the core.
// R12: Wake only on new flag setting; software presets flag to suppress.
// R13: Enabled comparator keeps running and updating during sleep or idle.
// R14: Selected pins read zero when direction is 1, else port data.
// R15: Software should switch comparator off when unused or before sleep.
// R16: Request flag bit 4, enable bit 0 of third interrupt control, reset 0.
// R17: Comparator interrupt needs the global enable as well.
// R18: Raw result synchronised before edge detection; one transition, one set.
// R19: Writes to result bit ignored; result reads 0 while switched off.
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

`define ACC_AW 3
`define ACC_DW 8

`define ACC_OFF_CTRL 3'h0
`define ACC_OFF_IRQC3 3'h1
`define ACC_OFF_GLOBAL 3'h2
`define ACC_OFF_EVT_STAT 3'h3
`define ACC_OFF_EVT_MASK 3'h4

`define ACC_CTRL_RST 8'h81
`define ACC_CTRL_WMASK 8'hEF
`define ACC_BIT_RESULT 4

`define ACC_BIT_FLAG 4
`define ACC_BIT_ENABLE 0
`define ACC_BIT_GIE 0

`define ACC_EVT_EDGE 0
`define ACC_EVT_WAKE 1
`define ACC_EVT_W 2

`define ACC_PIN_POS 0
`define ACC_PIN_NEG 1
`define ACC_PIN_OUT 2

`endif

// ===== acc_pkg.sv
// Types shared by the comparator control modules.
// Assumes acc_cfg.svh is on the include path.
`include "acc_cfg.svh"

package acc_pkg;

	// Control register layout, bit 7 first
	typedef struct packed {
		logic pin_owner_select;
		logic comparator_power_on;
		logic output_invert;
		logic compare_result;
		logic output_path_internal;
		logic irq_edge_sel_hi;
		logic irq_edge_sel_lo;
		logic hysteresis_on;
	} acc_ctrl_s;

	typedef enum logic [1:0] {
		ACC_EDGE_RISE = 2'h0,
		ACC_EDGE_FALL = 2'h1,
		ACC_EDGE_BOTH = 2'h3,
		ACC_EDGE_BOTH_ALT = 2'h2
	} acc_edge_e;

	// One register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`ACC_AW-1:0] addr;
		logic [`ACC_DW-1:0] wdata;
	} acc_bus_req_s;

	// Drive of the three shared pins
	typedef struct packed {
		logic [2:0] o;
		logic [2:0] oe;
	} acc_pad_s;

endpackage

// ===== acc_sync_edge.sv
// Synchroniser, polarity and result register with edge pulses.
// Assumes the raw comparator output is asynchronous to clk.
`timescale 1ns/10ps

module acc_sync_edge
	import acc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Analog side and controls
	input wire logic raw_in,
	input wire logic invert,
	input wire logic power_on,
	// Result and edges
	output logic result,
	output logic rise,
	output logic fall
);

	logic sync_a;
	logic sync_b;
	logic on_q;
	logic next_result;
	logic live;

	// Two stages; only the second is read
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= raw_in; // R18
			sync_b <= sync_a;
		end
	end

	assign next_result = power_on & (sync_b ^ invert); // R4 R5 R19
	// Edges from powering up or down are not result changes
	assign live = power_on & on_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			result <= 1'b0;
			on_q <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			result <= next_result; // R13
			on_q <= power_on;
			rise <= live & next_result & ~result; // R10 R18
			fall <= live & ~next_result & result;
		end
	end

endmodule

// ===== acc_top.sv
// Comparator control: control register, request flag, wake and pin muxing.
// Assumes synchronous inputs except cmp_raw, an 8-bit register port and an external
// interrupt controller that acknowledges the comparator vector.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "acc_cfg.svh"

module acc_top
	import acc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire acc_bus_req_s bus_req,
	output logic [`ACC_DW-1:0] rdata,
	// Analog comparator
	input wire logic cmp_raw,
	output logic cmp_power_on,
	output logic cmp_hysteresis_on,
	output logic cmp_inputs_connect,
	// Core power state and interrupt controller
	input wire logic core_sleep,
	input wire logic irq_ack,
	output logic cmp_irq_req,
	output logic wake_req,
	output logic irq,
	// Port logic of the three shared pins
	input wire acc_pad_s gpio_drive,
	input wire logic [2:0] gpio_pull,
	input wire logic [1:0] gpio_dir,
	input wire logic [1:0] gpio_data,
	input wire logic [2:0] pad_in,
	output acc_pad_s pad_drive,
	output logic [2:0] pad_pull,
	output logic [2:0] port_read
);

	// Address match of one register word
	function automatic logic hit(input logic [`ACC_AW-1:0] a,
		input logic [`ACC_AW-1:0] off);
		hit = (a == off);
	endfunction

	acc_ctrl_s ctrl;
	logic result;
	logic rise;
	logic fall;
	logic edge_hit;
	logic flag;
	logic flag_en;
	logic gie;
	logic [`ACC_EVT_W-1:0] evt_stat;
	logic [`ACC_EVT_W-1:0] evt_mask;
	logic [`ACC_EVT_W-1:0] evt_set;
	logic wr_ctrl;
	logic wr_irqc;
	logic wr_gie;
	logic wr_stat;
	logic wr_mask;
	logic new_set;
	logic next_flag;
	logic out_to_pin;
	logic sel_or_on;
	acc_edge_e edge_mode;
	logic [`ACC_DW-1:0] next_rdata;

	// Write decode
	assign wr_ctrl = bus_req.wr & hit(bus_req.addr, `ACC_OFF_CTRL);
	assign wr_irqc = bus_req.wr & hit(bus_req.addr, `ACC_OFF_IRQC3);
	assign wr_gie = bus_req.wr & hit(bus_req.addr, `ACC_OFF_GLOBAL);
	assign wr_stat = bus_req.wr & hit(bus_req.addr, `ACC_OFF_EVT_STAT);
	assign wr_mask = bus_req.wr & hit(bus_req.addr, `ACC_OFF_EVT_MASK);

	// Control register; the result bit is not stored here
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= acc_ctrl_s'(`ACC_CTRL_RST);
		end else if (wr_ctrl) begin
			ctrl <= acc_ctrl_s'(bus_req.wdata & `ACC_CTRL_WMASK); // R19
		end
	end

	// Analog controls
	assign cmp_power_on = ctrl.comparator_power_on; // R3
	assign cmp_hysteresis_on = ctrl.hysteresis_on; // R8
	assign cmp_inputs_connect = ctrl.pin_owner_select; // R1

	// Synchronised, polarity-corrected result
	acc_sync_edge u_sync_edge (
		.clk(clk),
		.rst(rst),
		.raw_in(cmp_raw),
		.invert(ctrl.output_invert),
		.power_on(ctrl.comparator_power_on),
		.result(result),
		.rise(rise),
		.fall(fall)
	);

	// Edge selection
	assign edge_mode = acc_edge_e'({ctrl.irq_edge_sel_hi,
		ctrl.irq_edge_sel_lo});

	always_comb begin
		case (edge_mode)
			ACC_EDGE_RISE: begin
				edge_hit = rise; // R7
			end
			ACC_EDGE_FALL: begin
				edge_hit = fall; // R7
			end
			ACC_EDGE_BOTH, ACC_EDGE_BOTH_ALT: begin
				edge_hit = rise | fall; // R7
			end
			default: begin
				edge_hit = 1'b0;
			end
		endcase
	end

	// Request flag: hardware set wins over software clear and acknowledge
	always_comb begin
		next_flag = flag;
		if (wr_irqc) begin
			next_flag = bus_req.wdata[`ACC_BIT_FLAG];
		end else if (irq_ack) begin
			next_flag = 1'b0;
		end
		if (edge_hit) begin
			next_flag = 1'b1; // R9 R10
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flag <= 1'b0; // R16
		end else begin
			flag <= next_flag;
		end
	end

	// Flag enable and global enable
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_en <= 1'b0; // R16
		end else if (wr_irqc) begin
			flag_en <= bus_req.wdata[`ACC_BIT_ENABLE];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			gie <= 1'b0;
		end else if (wr_gie) begin
			gie <= bus_req.wdata[`ACC_BIT_GIE];
		end
	end

	// Vector request to the interrupt controller
	assign cmp_irq_req = flag & flag_en & gie; // R9 R17

	// A wake needs a flag that was clear; a preset flag blocks it
	assign new_set = edge_hit & ~flag; // R12

	always_ff @(posedge clk) begin
		if (rst) begin
			wake_req <= 1'b0;
		end else begin
			wake_req <= new_set & core_sleep &
				ctrl.comparator_power_on; // R11 R13
		end
	end

	// Sticky event status, write one to clear; new events win
	always_comb begin
		evt_set = '0;
		evt_set[`ACC_EVT_EDGE] = edge_hit;
		evt_set[`ACC_EVT_WAKE] = new_set & core_sleep &
			ctrl.comparator_power_on;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			evt_stat <= '0;
		end else if (wr_stat) begin
			evt_stat <= (evt_stat &
				~bus_req.wdata[`ACC_EVT_W-1:0]) | evt_set;
		end else begin
			evt_stat <= evt_stat | evt_set;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			evt_mask <= '0;
		end else if (wr_mask) begin
			evt_mask <= bus_req.wdata[`ACC_EVT_W-1:0];
		end
	end

	assign irq = |(evt_stat & evt_mask);

	// Read data, valid in the cycle after the read strobe only
	always_comb begin
		next_rdata = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				`ACC_OFF_CTRL: begin
					next_rdata = ctrl;
					// Power-off masks the result at once, not a cycle late
					next_rdata[`ACC_BIT_RESULT] = result &
						ctrl.comparator_power_on; // R5 R19
				end
				`ACC_OFF_IRQC3: begin
					next_rdata[`ACC_BIT_FLAG] = flag;
					next_rdata[`ACC_BIT_ENABLE] = flag_en;
				end
				`ACC_OFF_GLOBAL: begin
					next_rdata[`ACC_BIT_GIE] = gie;
				end
				`ACC_OFF_EVT_STAT: begin
					next_rdata[`ACC_EVT_W-1:0] = evt_stat;
				end
				`ACC_OFF_EVT_MASK: begin
					next_rdata[`ACC_EVT_W-1:0] = evt_mask;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	// Pin ownership
	assign out_to_pin = ctrl.pin_owner_select &
		~ctrl.output_path_internal; // R6
	assign sel_or_on = ctrl.pin_owner_select | ctrl.comparator_power_on;

	always_comb begin
		pad_drive = gpio_drive;
		if (ctrl.pin_owner_select) begin
			pad_drive.o[`ACC_PIN_POS] = 1'b0; // R1
			pad_drive.oe[`ACC_PIN_POS] = 1'b0;
			pad_drive.o[`ACC_PIN_NEG] = 1'b0;
			pad_drive.oe[`ACC_PIN_NEG] = 1'b0;
		end
		if (out_to_pin) begin
			pad_drive.o[`ACC_PIN_OUT] = result; // R6 R10
			pad_drive.oe[`ACC_PIN_OUT] = 1'b1;
		end
	end

	// Pull-ups of the input pins drop while the comparator has them or is powered on
	always_comb begin
		pad_pull = gpio_pull;
		if (sel_or_on) begin
			pad_pull[`ACC_PIN_POS] = 1'b0; // R2
			pad_pull[`ACC_PIN_NEG] = 1'b0;
		end
	end

	// Port read-back of the input pins while they are taken over
	always_comb begin
		port_read = pad_in;
		if (ctrl.pin_owner_select) begin
			port_read[`ACC_PIN_POS] = gpio_dir[`ACC_PIN_POS] ? 1'b0 :
				gpio_data[`ACC_PIN_POS]; // R14
			port_read[`ACC_PIN_NEG] = gpio_dir[`ACC_PIN_NEG] ? 1'b0 :
				gpio_data[`ACC_PIN_NEG]; // R14
		end
	end

endmodule

// ===== acc_checker_assertions.sv
// Port checker of the comparator control block.
// Assumes it is bound into acc_top and sees only its ports.
`timescale 1ns/10ps
`include "acc_cfg.svh"

module acc_checker
	import acc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire acc_bus_req_s bus_req,
	input wire logic [`ACC_DW-1:0] rdata,
	// Comparator and core
	input wire logic cmp_power_on,
	input wire logic cmp_hysteresis_on,
	input wire logic cmp_inputs_connect,
	input wire logic core_sleep,
	input wire logic wake_req,
	// Pins
	input wire acc_pad_s gpio_drive,
	input wire logic [1:0] gpio_dir,
	input wire logic [1:0] gpio_data,
	input wire acc_pad_s pad_drive,
	input wire logic [2:0] pad_pull,
	input wire logic [2:0] port_read
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr;
		bus_req.wr && bus_req.addr == `ACC_OFF_CTRL;
	endsequence
	sequence s_pulse;
		wake_req ##1 !wake_req;
	endsequence
	property p_pwr;
		s_wr |=> cmp_power_on == $past(bus_req.wdata[6]);
	endproperty
	property p_hys;
		s_wr |=> cmp_hysteresis_on == $past(bus_req.wdata[0]);
	endproperty
	property p_sel;
		s_wr |=> cmp_inputs_connect == $past(bus_req.wdata[7]);
	endproperty
	property p_pull;
		cmp_inputs_connect || cmp_power_on |-> pad_pull[1:0] == 2'h0;
	endproperty
	property p_read;
		cmp_inputs_connect |-> port_read[1:0] == (~gpio_dir & gpio_data);
	endproperty
	property p_off;
		bus_req.rd && bus_req.addr == `ACC_OFF_CTRL && !cmp_power_on
			|=> !rdata[4];
	endproperty
	property p_wake;
		wake_req |-> $past(core_sleep) && $past(cmp_power_on) ##0 s_pulse;
	endproperty
	property p_pin;
		!cmp_inputs_connect |-> pad_drive.o[2] == gpio_drive.o[2]
			&& pad_drive.oe[2] == gpio_drive.oe[2];
	endproperty
	a_pwr: assert property (p_pwr) else $error("power bit");
	a_hys: assert property (p_hys) else $error("hysteresis bit");
	a_sel: assert property (p_sel) else $error("pin select");
	a_pull: assert property (p_pull) else $error("pull-up kept");
	a_read: assert property (p_read) else $error("pin read-back");
	a_off: assert property (p_off) else $error("result while off");
	a_wake: assert property (p_wake) else $error("bad wake pulse");
	a_pin: assert property (p_pin) else $error("output pin taken");
endmodule

bind acc_top acc_checker acc_checker_inst (.clk, .rst, .bus_req, .rdata,
	.cmp_power_on, .cmp_hysteresis_on, .cmp_inputs_connect, .core_sleep,
	.wake_req, .gpio_drive, .gpio_dir, .gpio_data, .pad_drive, .pad_pull,
	.port_read);

// ===== test_acc_top.sv
// Self-checking bench of the comparator control block.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps
`include "acc_cfg.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end

module test_acc_top
	import acc_pkg::*;
;
	logic clk = 0;
	logic rst = 1;
	acc_bus_req_s bus_req = '0;
	acc_pad_s gpio_drive = '0;
	acc_pad_s pad_drive;
	logic [7:0] rdata, c;
	logic cmp_raw = 0, core_sleep = 0, irq_ack = 0;
	logic [2:0] gpio_pull = 0, pad_in = 0, pad_pull, port_read;
	logic [1:0] gpio_dir = 0, gpio_data = 0, sel;
	logic cmp_power_on, cmp_hysteresis_on, cmp_inputs_connect;
	logic cmp_irq_req, wake_req, irq, inv, gie, pre, oldr, hit, fl;
	logic [31:0] rs = 32'h8B68;
	int err_total = 0, cmp_count = 0, cyc = 0, wk = 0, wk_exp = 0;

	acc_top acc_top_inst (.clk, .rst, .bus_req, .rdata, .cmp_raw,
		.cmp_power_on, .cmp_hysteresis_on, .cmp_inputs_connect, .core_sleep,
		.irq_ack, .cmp_irq_req, .wake_req, .irq, .gpio_drive, .gpio_pull,
		.gpio_dir, .gpio_data, .pad_in, .pad_drive, .pad_pull, .port_read);

	always #2.5 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e, string n);
		@(posedge clk);
		bus_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		bus_req <= '0;
		#1 `CHK(n, e, rdata)
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Wake pulses are counted; a hang ends the run
	always @(posedge clk) begin
		cyc++;
		if (wake_req === 1'b1)
			wk++;
		if (cyc == 5000) begin
			err_total++;
			summarize;
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(`ACC_OFF_CTRL, 8'h81, "ctrl rst");
		rd(`ACC_OFF_IRQC3, 8'h00, "irq rst");
		rd(3'h7, 8'h00, "unmapped");
		wr(`ACC_OFF_EVT_MASK, 8'h01);
		for (int i = 0; i < 32; i++) begin
			rs = xs(rs);
			sel = i[1:0];
			inv = i[2];
			pre = rs[2];
			gie = rs[3];
			cmp_raw <= rs[4];
			gpio_drive <= rs[13:8];
			gpio_dir <= rs[15:14];
			gpio_data <= rs[17:16];
			pad_in <= rs[20:18];
			gpio_pull <= rs[23:21];
			c = {rs[0], 1'b1, inv, 1'b1, rs[1], sel, rs[5]};
			wr(`ACC_OFF_CTRL, c);
			repeat (6) @(posedge clk);
			#1 oldr = rs[4] ^ inv;
			`CHK("hyst", rs[5], cmp_hysteresis_on)
			`CHK("pin2", rs[0] & !rs[1] ? oldr : gpio_drive.o[2],
				pad_drive.o[2])
			rd(`ACC_OFF_CTRL, (c & 8'hEF) | {oldr, 4'h0}, "ctrl");
			wr(`ACC_OFF_GLOBAL, {7'h00, gie});
			wr(`ACC_OFF_IRQC3, {3'h0, pre, 4'h1});
			wr(`ACC_OFF_EVT_STAT, 8'h03);
			core_sleep <= 1'b1;
			cmp_raw <= !rs[4];
			repeat (6) @(posedge clk);
			core_sleep <= 1'b0;
			#1;
			hit = sel[1] | (sel[0] ^ !oldr);
			fl = pre | hit;
			wk_exp += int'(hit & !pre);
			`CHK("irq", hit, irq)
			`CHK("req", fl & gie, cmp_irq_req)
			`CHK("wake", wk_exp, wk)
			rd(`ACC_OFF_IRQC3, {3'h0, fl, 4'h1}, "flag");
		end
		wr(`ACC_OFF_IRQC3, 8'h11);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		rd(`ACC_OFF_IRQC3, 8'h01, "ack");
		wr(`ACC_OFF_EVT_STAT, 8'h03);
		#1 `CHK("irq clr", 1'b0, irq)
		wr(`ACC_OFF_CTRL, 8'hBF);
		rd(`ACC_OFF_CTRL, 8'hAF, "off");
		summarize;
	end
endmodule
